// File: src/acl_link_ctrl.sv
// Audio codec link controller: frame slots 0 to 4, registers, DMA requests.
// Assumes a codec that supplies the bit clock and a plain register port.
// Overview of operation
// R1 - Shift input on bit clock, decode tags
// R2 - Update slot only when tagged; ignore 5-12
// R3 - Valid slots 1-4 load registers, set flags
// R4 - Overrun overwrites unread data, flags it
// R5 - Drive output on clock, set tag bits
// R6 - Send slots only when previously requested
// R7 - Payload in slots 1-4; writes update flags
// R8 - Underrun resends held transmit value
// R9 - 20-bit slot value in 32-bit word
// R10 - DMA slots 3,4; 16 or 20 bit size
// R11 - 20-bit: request per slot, mono one
// R12 - 16-bit: both samples packed left word
// R13 - Clearing DMA enable stops requests
// R14 - Each event has its own enable bit
// R15 - Write 0 clears flag, 1 keeps
// R16 - Software clears command flags before writes
// R17 - Controller generates frame sync itself
// R18 - Software idles link before clock stop
// R19 - Address slot 1, data slot 2, captured
// R20 - Samples held left-justified in registers
// R21 - Codec power-down needs reset to resume
// R22 - 256-bit frame, MSB first, edge timing
module acl_link_ctrl
  import acl_pkg::*;
(
  input wire logic core_clk_in, // 200 MHz core clock
  input wire logic resetn_in, // Synchronous reset, low
  input wire logic [7:0] reg_addr_in, // Register byte address
  input wire logic [31:0] reg_wdata_in, // Write data
  input wire logic reg_wr_in, // Write strobe
  input wire logic reg_rd_in, // Read strobe
  output logic [31:0] reg_rdata_out, // Read data, next cycle
  input wire logic codec_bit_clock_in, // Codec bit clock pin
  input wire logic codec_serial_in_in, // Codec data pin
  output logic codec_serial_out_out, // Data to codec
  output logic frame_sync_out, // Frame sync to codec
  output logic rx_dma_req_out, // Receive DMA request
  output logic tx_dma_req_out, // Transmit DMA request
  output logic irq_out // Combined event request
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  acl_bus_s bus; // Bundled register request
  logic [2:0] bclk_sync_q; // Bit clock synchroniser and history
  logic [1:0] sdin_sync_q; // Data input synchroniser
  logic rise; // Bit clock rising edge
  logic fall; // Bit clock falling edge
  logic [7:0] bit_cnt_q; // Position in frame, output side
  logic [7:0] rx_cnt_q; // Position in frame, input side
  logic [19:0] rx_shift_q; // Incoming slot shifter
  logic [4:0] rx_tag_q; // Received valid tags, slots 0-4
  logic [1:0] req_q; // Slot 3/4 request bits (low = request)
  logic [4:0] tx_tag_q; // Tags latched for current frame
  logic [19:0] tx_shift_q; // Outgoing slot shifter
  logic [31:0] ctl_q; // Link control
  logic [5:0] tx_st_q; // Transmit flags
  logic [5:0] rx_st_q; // Receive flags
  logic [5:0] tx_ie_q; // Transmit enables
  logic [5:0] rx_ie_q; // Receive enables
  logic [19:0] addr_q; // Codec register address
  logic [19:0] data_q; // Codec register data
  logic [19:0] left_q; // Left sample
  logic [19:0] right_q; // Right sample
  logic [19:0] tx_addr_q; // Command address to send
  logic [19:0] tx_data_q; // Command data to send
  logic [19:0] tx_left_q; // Playback left
  logic [19:0] tx_right_q; // Playback right
  logic [5:0] rx_set; // Receive events this cycle
  logic [5:0] tx_set; // Transmit events this cycle
  logic slot_end; // Last bit of a data slot received
  logic [2:0] slot_no; // Slot just received
  logic wr_left; // Software write of left word
  logic wr_right; // Software write of right word
  logic rd_left; // Software read of left word
  logic rd_right; // Software read of right word

  assign bus = '{addr: reg_addr_in, wdata: reg_wdata_in,
                 wr: reg_wr_in, rd: reg_rd_in};

  // Slot number of a frame bit position
  function automatic logic [3:0] slot_of(input logic [7:0] pos);
    if (pos < 8'(TAG_BITS)) begin
      slot_of = 4'h0;
    end else begin
      slot_of = 4'(((32'(pos) - TAG_BITS) / SLOT_BITS) + 1);
    end
  endfunction

  // Bit offset inside its slot
  function automatic logic [4:0] offs_of(input logic [7:0] pos);
    if (pos < 8'(TAG_BITS)) begin
      offs_of = pos[4:0];
    end else begin
      offs_of = 5'((32'(pos) - TAG_BITS) % SLOT_BITS);
    end
  endfunction

  // ****************************************************************
  // Pin synchronisers and bit clock edges
  // ****************************************************************
  // Two flops before any logic; third flop gives edge history
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      bclk_sync_q <= 3'h0;
      sdin_sync_q <= 2'h0;
    end else begin
      bclk_sync_q <= {bclk_sync_q[1:0], codec_bit_clock_in};
      sdin_sync_q <= {sdin_sync_q[0], codec_serial_in_in};
    end
  end
  assign rise = bclk_sync_q[1] & ~bclk_sync_q[2];
  assign fall = ~bclk_sync_q[1] & bclk_sync_q[2];

  // ****************************************************************
  // Frame counter, sync and transmit shifter
  // ****************************************************************
  // Output side advances on rising edges
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      bit_cnt_q <= 8'hFF;
      frame_sync_out <= 1'b0;
      codec_serial_out_out <= 1'b0;
      tx_shift_q <= 20'h00000;
      tx_tag_q <= 5'h00;
    end else if (rise && ctl_q[CTL_LINK_EN]) begin
      bit_cnt_q <= bit_cnt_q + 8'h01; // see R22
      frame_sync_out <= (bit_cnt_q == 8'hFF) ||
                        (bit_cnt_q < SYNC_END); // see R17
      if (bit_cnt_q == 8'hFF) begin
        // New frame: tag slots 3/4 when requested, 1/2 when their flag is clear, see R6
        tx_tag_q <= {~req_q[1], ~req_q[0], tx_st_q[ST_SLOT2] == 1'b0,
                     tx_st_q[ST_SLOT1] == 1'b0, 1'b1};
        codec_serial_out_out <= 1'b1; // Frame valid bit, see R5
        tx_shift_q <= {tx_st_q[ST_SLOT1] == 1'b0, tx_st_q[ST_SLOT2] == 1'b0,
                       ~req_q[0], ~req_q[1], 16'h0000}; // see R5
      end else if (offs_of(bit_cnt_q + 8'h02) == 5'h00) begin
        // Load one bit early so the MSB leads the slot; 5-12 zeros, see R7
        case (slot_of(bit_cnt_q + 8'h02))
          4'h1: tx_shift_q <= tx_tag_q[1] ? tx_addr_q : 20'h00000;
          4'h2: tx_shift_q <= tx_tag_q[2] ? tx_data_q : 20'h00000;
          4'h3: tx_shift_q <= tx_tag_q[3] ? tx_left_q : 20'h00000;
          4'h4: tx_shift_q <= tx_tag_q[4] ? tx_right_q : 20'h00000;
          default: tx_shift_q <= 20'h00000;
        endcase
        codec_serial_out_out <= tx_shift_q[19]; // Last bit of old slot
      end else begin
        codec_serial_out_out <= tx_shift_q[19]; // see R22
        tx_shift_q <= {tx_shift_q[18:0], 1'b0};
      end
    end
  end

  // ****************************************************************
  // Receive shifter and tag decode
  // ****************************************************************
  // Input sampled on falling edges, see R1
  assign slot_end = fall && ctl_q[CTL_LINK_EN] &&
                    (rx_cnt_q >= 8'(TAG_BITS)) &&
                    (offs_of(rx_cnt_q) == 5'(SLOT_BITS - 1));
  assign slot_no = (slot_of(rx_cnt_q) <= 4'h4) ? 3'(slot_of(rx_cnt_q)) : 3'h0;

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      rx_cnt_q <= 8'h00;
      rx_shift_q <= 20'h00000;
      rx_tag_q <= 5'h00;
    end else if (fall && ctl_q[CTL_LINK_EN]) begin
      rx_cnt_q <= bit_cnt_q;
      rx_shift_q <= {rx_shift_q[18:0], sdin_sync_q[1]};
      if (bit_cnt_q == 8'(TAG_BITS - 1)) begin
        // Slot 0 complete; tags of slots 5-12 dropped, see R2
        rx_tag_q <= {rx_shift_q[10], rx_shift_q[11], rx_shift_q[12],
                     rx_shift_q[13], rx_shift_q[14]};
      end
    end
  end

  // Slot 1 of input carries request bits 3/4 (low = send), see R6
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      req_q <= 2'h3;
    end else if (slot_end && slot_no == 3'h1) begin
      req_q <= {rx_shift_q[10], rx_shift_q[11]};
    end
  end

  // ****************************************************************
  // Holding registers and events
  // ****************************************************************
  assign wr_left = bus.wr && bus.addr == OFS_LEFT;
  assign wr_right = bus.wr && bus.addr == OFS_RIGHT;
  assign rd_left = bus.rd && bus.addr == OFS_LEFT;
  assign rd_right = bus.rd && bus.addr == OFS_RIGHT;

  // Receive data only on tagged slots 1-4, see R2
  always_comb begin
    rx_set = 6'h00;
    if (slot_end && slot_no >= 3'h1 && slot_no <= 3'h4 &&
        rx_tag_q[slot_no]) begin
      rx_set[slot_no - 3'h1] = 1'b1; // see R3
      if (slot_no == 3'h3 && rx_st_q[ST_SLOT3]) begin
        rx_set[ST_ERR_L] = 1'b1; // see R4
      end
      if (slot_no == 3'h4 && rx_st_q[ST_SLOT4]) begin
        rx_set[ST_ERR_R] = 1'b1; // see R4
      end
    end
  end

  // Transmit events at frame start; flag high means buffer empty
  always_comb begin
    tx_set = 6'h00;
    if (rise && ctl_q[CTL_LINK_EN] && bit_cnt_q == 8'hFF) begin
      tx_set[ST_SLOT1] = tx_st_q[ST_SLOT1] == 1'b0; // see R19
      tx_set[ST_SLOT2] = tx_st_q[ST_SLOT2] == 1'b0;
      tx_set[ST_SLOT3] = ~req_q[0];
      tx_set[ST_SLOT4] = ~req_q[1];
      tx_set[ST_ERR_L] = ~req_q[0] & tx_st_q[ST_SLOT3]; // see R8
      tx_set[ST_ERR_R] = ~req_q[1] & tx_st_q[ST_SLOT4];
    end
  end

  // Captured status and samples, left-justified, see R20
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      addr_q <= 20'h00000;
      data_q <= 20'h00000;
      left_q <= 20'h00000;
      right_q <= 20'h00000;
    end else if (rx_set[ST_SLOT1]) begin
      addr_q <= rx_shift_q; // see R19
    end else if (rx_set[ST_SLOT2]) begin
      data_q <= rx_shift_q;
    end else if (rx_set[ST_SLOT3]) begin
      left_q <= rx_shift_q; // Overwrites unread, see R4
    end else if (rx_set[ST_SLOT4]) begin
      right_q <= rx_shift_q;
    end
  end

  // Transmit buffers keep old value until rewritten, see R8
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      tx_addr_q <= 20'h00000;
      tx_data_q <= 20'h00000;
      tx_left_q <= 20'h00000;
      tx_right_q <= 20'h00000;
    end else if (bus.wr) begin
      case (bus.addr)
        OFS_CODEC_ADDR: tx_addr_q <= bus.wdata[31:12]; // see R9
        OFS_CODEC_DATA: tx_data_q <= bus.wdata[31:12];
        OFS_LEFT: begin
          if (ctl_q[CTL_TX_HALF]) begin
            // Packed left and right halves, see R12
            tx_left_q <= {bus.wdata[31:16], 4'h0};
            tx_right_q <= {bus.wdata[15:0], 4'h0};
          end else begin
            tx_left_q <= bus.wdata[31:12];
          end
        end
        OFS_RIGHT: tx_right_q <= bus.wdata[31:12];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Control and enable registers
  // ****************************************************************
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      ctl_q <= CTL_RESET;
      tx_ie_q <= ST_RESET;
      rx_ie_q <= ST_RESET;
    end else if (bus.wr) begin
      case (bus.addr)
        OFS_LINK_CONTROL: ctl_q <= {26'h0, bus.wdata[5:0]}; // see R13
        OFS_TX_INT_EN: tx_ie_q <= bus.wdata[5:0]; // see R14
        OFS_RX_INT_EN: rx_ie_q <= bus.wdata[5:0];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Status flags: set wins, write 0 clears, write 1 keeps
  // ****************************************************************
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      rx_st_q <= ST_RESET;
    end else begin
      rx_st_q <= (rx_st_q & ~((bus.wr && bus.addr == OFS_RX_STATUS) ?
                 ~bus.wdata[5:0] : 6'h00)
                 & ~(rd_left && !ctl_q[CTL_RX_HALF] ? 6'h04 : 6'h00)
                 & ~(rd_left && ctl_q[CTL_RX_HALF] ? 6'h0C : 6'h00)
                 & ~(rd_right ? 6'h08 : 6'h00)) | rx_set; // see R15
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      tx_st_q <= ST_RESET;
    end else begin
      tx_st_q <= (tx_st_q & ~((bus.wr && bus.addr == OFS_TX_STATUS) ?
                 ~bus.wdata[5:0] : 6'h00)
                 & ~(wr_left && !ctl_q[CTL_TX_HALF] ? 6'h04 : 6'h00)
                 & ~(wr_left && ctl_q[CTL_TX_HALF] ? 6'h0C : 6'h00)
                 & ~(wr_right ? 6'h08 : 6'h00)) | tx_set; // see R7
    end
  end

  // ****************************************************************
  // DMA requests and event output
  // ****************************************************************
  // Requests gated by enables; mono uses slot 3 only, see R10 R11
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      rx_dma_req_out <= 1'b0;
      tx_dma_req_out <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      rx_dma_req_out <= ctl_q[CTL_RX_DMA_EN] && (ctl_q[CTL_RX_HALF] ?
        rx_st_q[ST_SLOT3] && (ctl_q[CTL_MONO] || rx_st_q[ST_SLOT4]) :
        rx_st_q[ST_SLOT3] || (!ctl_q[CTL_MONO] && rx_st_q[ST_SLOT4]));
      tx_dma_req_out <= ctl_q[CTL_TX_DMA_EN] && (ctl_q[CTL_TX_HALF] ?
        tx_st_q[ST_SLOT3] && (ctl_q[CTL_MONO] || tx_st_q[ST_SLOT4]) :
        tx_st_q[ST_SLOT3] || (!ctl_q[CTL_MONO] && tx_st_q[ST_SLOT4]));
      irq_out <= |(rx_st_q & rx_ie_q) || |(tx_st_q & tx_ie_q); // see R14
    end
  end

  // ****************************************************************
  // Register read port
  // ****************************************************************
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (bus.rd) begin
      case (bus.addr)
        OFS_LINK_CONTROL: reg_rdata_out <= ctl_q;
        OFS_TX_STATUS: reg_rdata_out <= {26'h0, tx_st_q};
        OFS_RX_STATUS: reg_rdata_out <= {26'h0, rx_st_q};
        OFS_TX_INT_EN: reg_rdata_out <= {26'h0, tx_ie_q};
        OFS_RX_INT_EN: reg_rdata_out <= {26'h0, rx_ie_q};
        OFS_CODEC_ADDR: reg_rdata_out <= {addr_q, 12'h000}; // see R9
        OFS_CODEC_DATA: reg_rdata_out <= {data_q, 12'h000};
        OFS_LEFT: reg_rdata_out <= ctl_q[CTL_RX_HALF] ?
          {left_q[19:4], right_q[19:4]} : {left_q, 12'h000}; // see R12
        OFS_RIGHT: reg_rdata_out <= {right_q, 12'h000};
        default: reg_rdata_out <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_out <= 32'h0000_0000;
    end
  end

endmodule // acl_link_ctrl

// File: src/acl_pkg.sv
// Package for the audio codec link controller.
// Assumes one 200 MHz core clock; the codec bit clock is sampled as data.
package acl_pkg;

  // ****************************************************************
  // Register offsets (byte addresses, one 32-bit word each)
  // ****************************************************************
  localparam logic [7:0] OFS_LINK_CONTROL = 8'h00; // Control
  localparam logic [7:0] OFS_TX_STATUS = 8'h04; // Transmit flags
  localparam logic [7:0] OFS_RX_STATUS = 8'h08; // Receive flags
  localparam logic [7:0] OFS_TX_INT_EN = 8'h0C; // Transmit enables
  localparam logic [7:0] OFS_RX_INT_EN = 8'h10; // Receive enables
  localparam logic [7:0] OFS_CODEC_ADDR = 8'h14; // Slot 1 value
  localparam logic [7:0] OFS_CODEC_DATA = 8'h18; // Slot 2 value
  localparam logic [7:0] OFS_LEFT = 8'h1C; // Slot 3 sample
  localparam logic [7:0] OFS_RIGHT = 8'h20; // Slot 4 sample

  // ****************************************************************
  // Link control field positions
  // ****************************************************************
  localparam int CTL_RX_DMA_EN = 0; // Receive DMA enable
  localparam int CTL_TX_DMA_EN = 1; // Transmit DMA enable
  localparam int CTL_RX_HALF = 2; // Receive DMA 16-bit size
  localparam int CTL_TX_HALF = 3; // Transmit DMA 16-bit size
  localparam int CTL_MONO = 4; // Only slot 3 requests DMA
  localparam int CTL_LINK_EN = 5; // Frame generation on
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;

  // ****************************************************************
  // Status flag positions, shared by both status registers
  // ****************************************************************
  localparam int ST_SLOT1 = 0; // Slot 1 ready / sent
  localparam int ST_SLOT2 = 1; // Slot 2 ready / sent
  localparam int ST_SLOT3 = 2; // Left ready / requested
  localparam int ST_SLOT4 = 3; // Right ready / requested
  localparam int ST_ERR_L = 4; // Overrun or underrun left
  localparam int ST_ERR_R = 5; // Overrun or underrun right
  localparam int ST_W = 6; // Flag count
  localparam logic [5:0] ST_RESET = 6'h00;

  // ****************************************************************
  // Frame geometry
  // ****************************************************************
  localparam int FRAME_BITS = 256; // Bit clocks per frame
  localparam int TAG_BITS = 16; // Slot 0 length
  localparam int SLOT_BITS = 20; // Data slot length
  localparam logic [7:0] SYNC_END = 8'h0F; // Last sync bit

  // Bus request carrier
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } acl_bus_s;

endpackage : acl_pkg

// File: test/acl_codec_model.sv
// Behavioural codec on the serial link: bit clock, frames out, frames in.
// Assumes the controller starts each frame with a rising frame sync.
module acl_codec_model
  import acl_pkg::*;
(
  input wire logic frame_sync_in, // Frame sync from controller
  input wire logic serial_from_ctrl_in, // Controller data out
  input wire logic [15:0] tag_in, // Slot 0 of our frames
  input wire logic [79:0] slots_in, // Slots 1 to 4
  output logic bit_clock_out, // Free running bit clock
  output logic serial_to_ctrl_out, // Our data to controller
  output logic [255:0] last_frame_out, // Last frame received
  output logic [255:0] cmd_frame_out // Last frame with slot 1 tagged
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************************************
  // Framing
  // ****************************************************************
  wire logic [255:0] frame = {tag_in, slots_in, {8{20'hF0F0F}}};
  logic [7:0] pos = 8'hFF; // Bit position in frame
  logic seen = 1'b0; // Sync level at last rise
  logic [255:0] rx_sh = '0; // Incoming shift register

  initial begin
    bit_clock_out = 1'b0;
    serial_to_ctrl_out = 1'b0;
    last_frame_out = '0;
    cmd_frame_out = '0;
  end
  // 80 ns bit clock, free running
  always #40 bit_clock_out = ~bit_clock_out;

  // Drive after rising edge, MSB first, find slot 0 from sync
  always @(posedge bit_clock_out) begin
    #25;
    pos = (frame_sync_in && !seen) ? 8'h00 : pos + 8'h01;
    seen = frame_sync_in;
    serial_to_ctrl_out = frame[8'hFF - pos];
  end

  // Sample controller data on falling edge, keep whole frames
  always @(negedge bit_clock_out) begin
    rx_sh = {rx_sh[254:0], serial_from_ctrl_in};
    if (pos == 8'hFF) begin
      last_frame_out = rx_sh;
      if (rx_sh[254]) cmd_frame_out = rx_sh;
    end
  end
endmodule // acl_codec_model

// File: test/acl_link_ctrl_assertions.sv
// Checker for the link controller, bound to its ports.
// Assumes one core clock domain and a bus master that never overlaps strobes.
module acl_link_ctrl_assertions
  import acl_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  input wire logic codec_bit_clock_in,
  input wire logic codec_serial_in_in,
  input wire logic codec_serial_out_out,
  input wire logic frame_sync_out,
  input wire logic rx_dma_req_out,
  input wire logic tx_dma_req_out,
  input wire logic irq_out
);
  // ****************************************************************
  // Helper state
  // ****************************************************************
  logic [31:0] ctl_q; // Mirror of link control
  logic [1:0] ie_q; // Any event enable, tx and rx
  logic link_q; // Link has been enabled once
  logic bc_q, sync_q, seen_q; // Previous samples, first frame seen
  logic [8:0] bits_q; // Bit clocks since sync rose
  logic [3:0] since_q; // Core cycles since a bit clock rise
  wire logic bc_rise = codec_bit_clock_in & ~bc_q;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!resetn_in);

  // Register writes mirrored from the bus
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      ctl_q <= 32'h0000_0000;
      ie_q <= 2'b00;
      link_q <= 1'b0;
    end else begin
      if (reg_wr_in && reg_addr_in == OFS_LINK_CONTROL) ctl_q <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == OFS_TX_INT_EN) ie_q[0] <= |reg_wdata_in;
      if (reg_wr_in && reg_addr_in == OFS_RX_INT_EN) ie_q[1] <= |reg_wdata_in;
      link_q <= link_q | ctl_q[CTL_LINK_EN];
    end
  end

  // Bit clock edges counted against frame sync
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      {bc_q, sync_q, seen_q} <= 3'b000;
      bits_q <= 9'h000;
      since_q <= 4'h0;
    end else begin
      bc_q <= codec_bit_clock_in;
      sync_q <= frame_sync_out;
      seen_q <= seen_q | (frame_sync_out & ~sync_q);
      bits_q <= (frame_sync_out & ~sync_q) ? 9'h000 : bits_q + 9'(bc_rise);
      since_q <= bc_rise ? 4'h0 : ((since_q == 4'hF) ? 4'hF : since_q + 4'h1);
    end
  end

  // ****************************************************************
  // Properties
  // ****************************************************************
  chk_sync_length: assert property (
    $fell(frame_sync_out) |-> bits_q == 9'd16) else $error("sync length");
  chk_frame_period: assert property (
    $rose(frame_sync_out) && seen_q |-> bits_q == 9'd256)
    else $error("frame length");
  chk_data_edge: assert property (
    $changed(codec_serial_out_out) |-> since_q <= 4'h6)
    else $error("data moved off edge");
  chk_sync_edge: assert property (
    $changed(frame_sync_out) |-> since_q <= 4'h6) else $error("sync off edge");
  chk_link_idle: assert property (
    !link_q |-> !frame_sync_out && !codec_serial_out_out)
    else $error("link active while off");
  chk_rx_dma_gate: assert property (
    rx_dma_req_out |-> $past(ctl_q[CTL_RX_DMA_EN]) ||
      $past(ctl_q[CTL_RX_DMA_EN], 2)) else $error("rx request while off");
  chk_tx_dma_gate: assert property (
    tx_dma_req_out |-> $past(ctl_q[CTL_TX_DMA_EN]) ||
      $past(ctl_q[CTL_TX_DMA_EN], 2)) else $error("tx request while off");
  chk_irq_gate: assert property (
    irq_out |-> $past(ie_q) != 2'b00 || $past(ie_q, 2) != 2'b00)
    else $error("event without enable");
  chk_rdata_idle: assert property (
    !$past(reg_rd_in) |-> reg_rdata_out == 32'h0000_0000)
    else $error("read data outside slot");
  chk_unmapped_rd: assert property (
    $past(reg_rd_in) && $past(reg_addr_in) > OFS_RIGHT |->
      reg_rdata_out == 32'h0000_0000) else $error("unmapped read data");
endmodule // acl_link_ctrl_assertions

bind acl_link_ctrl acl_link_ctrl_assertions acl_link_ctrl_assertions_inst (
  .core_clk_in(core_clk_in), .resetn_in(resetn_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .codec_bit_clock_in(codec_bit_clock_in),
  .codec_serial_in_in(codec_serial_in_in),
  .codec_serial_out_out(codec_serial_out_out),
  .frame_sync_out(frame_sync_out), .rx_dma_req_out(rx_dma_req_out),
  .tx_dma_req_out(tx_dma_req_out), .irq_out(irq_out)
);

// File: test/acl_link_ctrl_test.sv
// Self-checking bench: register tasks and frame scenarios.
// Assumes the codec model supplies the bit clock and frame contents.
module acl_link_ctrl_test
  import acl_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0; // Core clock
  logic resetn = 1'b0; // Reset, active low
  logic [7:0] addr = 8'h00; // Bus address
  logic [31:0] wdata = 32'h0000_0000; // Bus write data
  logic wr = 1'b0, rd = 1'b0; // Bus strobes
  logic [31:0] rdata, d; // Bus read data, read result
  logic bclk, sdin, sdout, sync, rxreq, txreq, irq; // Pins and requests
  logic [15:0] tag = 16'hF7F8; // Slots 1-3 and 5-12 tagged
  logic [19:0] s1 = 20'h9A000, s2 = 20'h5A5A0, s3 = 20'hABCDE, s4 = 20'h12345;
  logic [255:0] last_f, cmd_f; // Frames seen by codec
  int errors = 0, n_tests = 0;

  always #2.5 core_clk = ~core_clk;

  acl_link_ctrl acl_link_ctrl_inst (.core_clk_in(core_clk), .resetn_in(resetn),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .codec_bit_clock_in(bclk),
    .codec_serial_in_in(sdin), .codec_serial_out_out(sdout),
    .frame_sync_out(sync), .rx_dma_req_out(rxreq), .tx_dma_req_out(txreq),
    .irq_out(irq));
  acl_codec_model acl_codec_model_inst (.frame_sync_in(sync),
    .serial_from_ctrl_in(sdout), .tag_in(tag), .slots_in({s1, s2, s3, s4}),
    .bit_clock_out(bclk), .serial_to_ctrl_out(sdin),
    .last_frame_out(last_f), .cmd_frame_out(cmd_f));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic summarize();
    if (errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // One-cycle write
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  // One-cycle read, data taken in the following cycle
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] q);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    @(posedge core_clk);
    q = rdata;
  endtask
  // Wait for n sync rises, bounded
  task automatic wait_frames(input int n);
    int seen;
    logic prev;
    seen = 0;
    prev = sync;
    for (int i = 0; i < 5000 * n && seen < n; i++) begin
      @(posedge core_clk);
      if (sync === 1'b1 && prev === 1'b0) seen++;
      prev = sync;
    end
    if (seen < n) begin
      errors++;
      summarize();
    end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    rd_reg(OFS_LINK_CONTROL, d);
    check(d, CTL_RESET);
    rd_reg(OFS_RX_STATUS, d);
    check(d, 32'(ST_RESET));
    wr_reg(8'h40, 32'hFFFF_FFFF);
    rd_reg(8'h40, d);
    check(d, 32'h0000_0000);
    // Setup before the link runs
    wr_reg(OFS_CODEC_ADDR, 32'h2600_0000);
    wr_reg(OFS_CODEC_DATA, 32'h8000_0000);
    wr_reg(OFS_LEFT, 32'h1357_9000);
    wr_reg(OFS_RIGHT, 32'h2468_A000);
    wr_reg(OFS_RX_INT_EN, 32'h0000_0004);
    check(32'(irq), 32'h0);
    wr_reg(OFS_LINK_CONTROL, 32'h0000_0020);
    wait_frames(3);
    rd_reg(OFS_RX_STATUS, d);
    check(d, 32'h0000_0017);
    check(32'(irq), 32'h1);
    wr_reg(OFS_RX_INT_EN, 32'h0000_0000);
    repeat (3) @(posedge core_clk);
    check(32'(irq), 32'h0);
    rd_reg(OFS_LEFT, d);
    check(d, 32'hABCD_E000);
    rd_reg(OFS_CODEC_DATA, d);
    check(d, 32'h5A5A_0000);
    check(32'({last_f[255], last_f[252:251]}), 32'h7);
    check(32'(last_f[199:180]), 32'h13579);
    check(32'(last_f[179:160]), 32'h2468A);
    check(32'(cmd_f[239:220]), 32'h0002_6000);
    check(32'(cmd_f[219:200]), 32'h0008_0000);
    rd_reg(OFS_TX_STATUS, d);
    check(32'(d[1:0]), 32'h3);
    wr_reg(OFS_RX_STATUS, 32'hFFFF_FFEF);
    rd_reg(OFS_RX_STATUS, d);
    check(d, 32'h0000_0003);
    wr_reg(OFS_TX_STATUS, 32'hFFFF_FFFC);
    // New sample overwrites; requests withdrawn
    s3 <= 20'h0F0F0;
    s1 <= 20'h9AC00;
    wait_frames(3);
    rd_reg(OFS_LEFT, d);
    check(d, 32'h0F0F_0000);
    check(32'(last_f[252:251]), 32'h0);
    // Packed 16-bit transfers with DMA on
    tag <= 16'hFFF8;
    s4 <= 20'hA5A5F;
    s1 <= 20'h9A000;
    wr_reg(OFS_LINK_CONTROL, 32'h0000_002F);
    wr_reg(OFS_LEFT, 32'h1234_5678);
    wait_frames(3);
    check(32'({rxreq, txreq}), 32'h3);
    rd_reg(OFS_LEFT, d);
    check(d, 32'h0F0F_A5A5);
    check(32'(last_f[199:180]), 32'h0001_2340);
    check(32'(last_f[179:160]), 32'h0005_6780);
    wr_reg(OFS_LINK_CONTROL, 32'h0000_002C);
    repeat (3) @(posedge core_clk);
    check(32'({rxreq, txreq}), 32'h0);
    summarize();
  end
endmodule // acl_link_ctrl_test
